// ### logic/clk_ctrl_pkg.sv
// Constants and types shared by the clock source and multiplier-loop control
// Behaviour
// R1 - Reset selects internal RC oscillator
// R2 - Software picks RC, crystal or RTC source
// R3 - Input pre-divider from 1 to 256
// R4 - Feedback divider from 1 to 32768
// R5 - Software keeps oscillator within 275-550 MHz
// R6 - Main loop off, bypassed after reset, power-down
// R7 - Enable, wait lock, then connect
// R8 - CPU clock equals input unless connected
// R9 - Each peripheral clock selected independently
// R10 - Crystal usable direct or through loop
// R11 - USB loop uses crystal, feeds USB only
// R12 - USB loop off after reset
// R13 - USB falls back to main-loop 48 MHz
// R14 - USB clock has 50 percent duty
// R15 - Lock status readable, glitch-free lock-gated switching
package clk_ctrl_pkg;

    //------------------------------------------------------------------
    // Register bus
    //------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_SRC_SEL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MAIN_CFG  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MAIN_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_USB_CTRL  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_USB_STAT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PCLK_SEL  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_DIV       = 8'h1C;

    //------------------------------------------------------------------
    // Field layout
    //------------------------------------------------------------------
    localparam int BIT_EN      = 0;
    localparam int BIT_CONN    = 1;
    localparam int BIT_LOCK    = 2;
    localparam int PRE_W       = 8;   // pre-divider minus one
    localparam int FB_W        = 15;  // feedback divider minus one
    localparam int CFG_FB_LSB  = 8;
    localparam int DIV_W       = 8;
    localparam int DIV_USB_LSB = 8;
    localparam int PCLK_SEL_W  = 2;

    //------------------------------------------------------------------
    // Reset values and timing counts
    //------------------------------------------------------------------
    localparam logic [DIV_W-1:0] CPU_DIV_RST     = 8'h03;
    localparam logic [DIV_W-1:0] USB_FB_DIV_RST  = 8'h04;
    localparam logic [PRE_W-1:0] USB_PRE_M1      = 8'h00;
    localparam logic [FB_W-1:0]  USB_FB_M1       = 15'h0003;
    localparam int               LOCK_REFS       = 8;

    //------------------------------------------------------------------
    // Types
    //------------------------------------------------------------------
    typedef enum logic [1:0] {SRC_IRC, SRC_MAIN, SRC_RTC} src_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } reg_req_t;

    typedef struct packed {
        logic rtc;
        logic main;
        logic internal_rc_osc;
    } osc_ticks_t;

    typedef struct packed {
        logic [FB_W-1:0]  fb_m1;
        logic [PRE_W-1:0] pre_m1;
        logic             pwr;
    } pll_cfg_t;

endpackage : clk_ctrl_pkg

// ### logic/tick_switch.sv
// Glitch-free selector between clock-enable tick streams
`timescale 1ns/10ps
module tick_switch #(
    parameter int N  = 3,
    parameter int SW = 2
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_nrst,
    input  wire logic [N-1:0]  i_tick,
    input  wire logic [SW-1:0] i_sel,
    output logic               o_tick,
    output logic [SW-1:0]      o_cur_sel
);
    typedef enum {ST_RUN, ST_DRAIN, ST_ARM} sw_state_t;

    sw_state_t       state_r;
    logic [SW-1:0]   cur_r;
    logic [SW-1:0]   tgt_r;
    logic            cur_tick;
    logic            tgt_tick;

    // Out-of-range indices read as silent sources
    assign cur_tick  = (32'(cur_r) < N) ? i_tick[cur_r] : 1'b0;
    assign tgt_tick  = (32'(tgt_r) < N) ? i_tick[tgt_r] : 1'b0;
    assign o_tick    = (state_r == ST_ARM) ? 1'b0 : cur_tick;
    assign o_cur_sel = cur_r;

    // Finish old tick, hold quiet, then start on a fresh new tick
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state_r <= ST_RUN;
            cur_r   <= '0;
            tgt_r   <= '0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (i_sel != cur_r && 32'(i_sel) < N) begin
                        tgt_r   <= i_sel;
                        state_r <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (cur_tick) state_r <= ST_ARM; // [R15]
                end
                ST_ARM: begin
                    if (tgt_tick) begin
                        cur_r   <= tgt_r;
                        state_r <= ST_RUN; // [R15]
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

endmodule : tick_switch

// ### logic/pll_lock_ctrl.sv
// Divider and lock detector around one multiplier loop oscillator
`timescale 1ns/10ps
module pll_lock_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int PW = PRE_W,
    parameter int FW = FB_W
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_en,
    input  wire logic          i_ref_tick,
    input  wire logic          i_cco_tick,
    input  wire logic [PW-1:0] i_pre_m1,
    input  wire logic [FW-1:0] i_fb_m1,
    output logic               o_locked
);
    logic [PW-1:0] pre_cnt_r;
    logic [FW-1:0] fb_cnt_r;
    logic [1:0]    seen_r;
    logic [3:0]    good_r;
    logic          ref_div;
    logic          fb_div;
    logic [1:0]    seen_tot;

    assign ref_div  = i_ref_tick && pre_cnt_r == i_pre_m1; // [R3]
    assign fb_div   = i_cco_tick && fb_cnt_r == i_fb_m1;   // [R4]
    assign seen_tot = (seen_r == 2'h2) ? seen_r : seen_r + {1'b0, fb_div};

    // Input and feedback dividers
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !i_en) begin
            pre_cnt_r <= '0;
            fb_cnt_r  <= '0;
        end else begin
            if (i_ref_tick) pre_cnt_r <= ref_div ? '0 : pre_cnt_r + 1'b1;
            if (i_cco_tick) fb_cnt_r  <= fb_div ? '0 : fb_cnt_r + 1'b1;
        end
    end

    // Frequency check: exactly one feedback edge per divided reference
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !i_en) begin
            seen_r   <= '0;
            good_r   <= '0;
            o_locked <= 1'b0;
        end else if (ref_div) begin
            seen_r <= '0;
            if (seen_tot == 2'h1) begin
                if (32'(good_r) < LOCK_REFS) good_r <= good_r + 1'b1;
                else o_locked <= 1'b1;
            end else begin
                good_r   <= '0;
                o_locked <= 1'b0;
            end
        end else begin
            seen_r <= seen_tot;
        end
    end

endmodule : pll_lock_ctrl

// ### logic/clk_ctrl_top.sv
// Clock source selection, main and USB multiplier loop control, clock enables
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module clk_ctrl_top #(
    parameter int NPER = 8
) (
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_nrst,
    input  wire clk_ctrl_pkg::reg_req_t      i_bus,
    output logic [clk_ctrl_pkg::DATA_W-1:0]  o_rdata,
    input  wire clk_ctrl_pkg::osc_ticks_t    i_osc,
    input  wire logic                        i_main_cco_tick,
    input  wire logic                        i_usb_cco_tick,
    input  wire logic                        i_power_down,
    output clk_ctrl_pkg::pll_cfg_t           o_main_pll_cfg,
    output logic                             o_usb_pll_pwr,
    output logic                             o_cpu_clk_en,
    output logic [NPER-1:0]                  o_pclk_en,
    output logic                             o_usb_clk
);
    import clk_ctrl_pkg::*;

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    logic [1:0]                 src_sel_r;
    logic                       main_en_r;
    logic                       main_conn_r;
    logic [PRE_W-1:0]           main_pre_r;
    logic [FB_W-1:0]            main_fb_r;
    logic                       usb_en_r;
    logic                       usb_conn_r;
    logic [DIV_W-1:0]           cpu_div_r;
    logic [DIV_W-1:0]           usb_fb_div_r;
    logic [PCLK_SEL_W*NPER-1:0] pclk_sel_r;
    logic [DATA_W-1:0]          rdata_nxt;
    logic [DIV_W-1:0]           cpu_cnt_r;
    logic [DIV_W-1:0]           usb_fb_cnt_r;
    logic                       usb_clk_r;

    logic                       main_locked;
    logic                       usb_locked;
    logic                       main_conn_eff;
    logic                       usb_conn_eff;
    logic                       pll_in_tick;
    logic                       pll_out_tick;
    logic                       cpu_tick;
    logic                       usb_fb_tick;
    logic                       usb_tick;
    logic                       wr;
    logic                       rd;

    assign wr = i_bus.we;
    assign rd = i_bus.re;

    //------------------------------------------------------------------
    // Source selection into the main loop
    //------------------------------------------------------------------
    // Three oscillators feed one glitch-free switch; reset starts on RC
    tick_switch #(
        .N  (3),
        .SW (2)
    ) u_src_switch (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_tick    ({i_osc.rtc, i_osc.main, i_osc.internal_rc_osc}),
        .i_sel     (src_sel_r), // [R2] [R10]
        .o_tick    (pll_in_tick),
        .o_cur_sel ()
    );

    //------------------------------------------------------------------
    // Main multiplier loop
    //------------------------------------------------------------------
    pll_lock_ctrl #(
        .PW (PRE_W),
        .FW (FB_W)
    ) u_main_lock (
        .i_ref_clk  (i_ref_clk),
        .i_nrst     (i_nrst),
        .i_en       (main_en_r),
        .i_ref_tick (pll_in_tick),
        .i_cco_tick (i_main_cco_tick),
        .i_pre_m1   (main_pre_r),  // [R3]
        .i_fb_m1    (main_fb_r),   // [R4]
        .o_locked   (main_locked)
    );

    // Analog loop sees power and divider settings straight from registers
    assign o_main_pll_cfg.pwr    = main_en_r;
    assign o_main_pll_cfg.pre_m1 = main_pre_r;
    assign o_main_pll_cfg.fb_m1  = main_fb_r;

    // Connection only counts while powered and locked
    assign main_conn_eff = main_en_r && main_conn_r && main_locked; // [R7] [R15]

    // A stopped loop hands over the bypass stream, so the switch never waits forever
    assign pll_out_tick = main_en_r ? (i_main_cco_tick && cpu_cnt_r == cpu_div_r)
                                    : pll_in_tick; // [R6]

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !main_en_r) begin
            cpu_cnt_r <= '0;
        end else if (i_main_cco_tick) begin
            cpu_cnt_r <= (cpu_cnt_r == cpu_div_r) ? '0 : cpu_cnt_r + 1'b1;
        end
    end

    //------------------------------------------------------------------
    // CPU clock: bypass or loop output
    //------------------------------------------------------------------
    // Bypass passes the selected input unchanged, so rates are equal
    tick_switch #(
        .N  (2),
        .SW (1)
    ) u_cpu_switch (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_tick    ({pll_out_tick, pll_in_tick}),
        .i_sel     (main_conn_eff), // [R8] [R15]
        .o_tick    (cpu_tick),
        .o_cur_sel ()
    );

    assign o_cpu_clk_en = cpu_tick;

    //------------------------------------------------------------------
    // Peripheral clock enables
    //------------------------------------------------------------------
    // Each peripheral divides the CPU tick by 1, 2, 4 or 8 on its own
    genvar gp;
    generate
        for (gp = 0; gp < NPER; gp++) begin : g_pclk
            logic [2:0] cnt_r;
            logic [1:0] sel;
            logic [2:0] mask;

            assign sel  = pclk_sel_r[gp*PCLK_SEL_W +: PCLK_SEL_W];
            assign mask = 3'((4'h1 << sel) - 4'h1);
            assign o_pclk_en[gp] = cpu_tick && (cnt_r & mask) == 3'h0; // [R9]

            always_ff @(posedge i_ref_clk) begin
                if (!i_nrst) begin
                    cnt_r <= '0;
                end else if (cpu_tick) begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // USB multiplier loop and fallback
    //------------------------------------------------------------------
    // Reference is the crystal only, whatever the main source is
    pll_lock_ctrl #(
        .PW (PRE_W),
        .FW (FB_W)
    ) u_usb_lock (
        .i_ref_clk  (i_ref_clk),
        .i_nrst     (i_nrst),
        .i_en       (usb_en_r),
        .i_ref_tick (i_osc.main),  // [R11]
        .i_cco_tick (i_usb_cco_tick),
        .i_pre_m1   (USB_PRE_M1),
        .i_fb_m1    (USB_FB_M1),
        .o_locked   (usb_locked)
    );

    assign o_usb_pll_pwr = usb_en_r; // [R12]
    assign usb_conn_eff  = usb_en_r && usb_conn_r && usb_locked; // [R15]

    // Main-loop derived ticks at twice 48 MHz for the fallback path
    assign usb_fb_tick = i_main_cco_tick && usb_fb_cnt_r == usb_fb_div_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !main_en_r) begin
            usb_fb_cnt_r <= '0;
        end else if (i_main_cco_tick) begin
            usb_fb_cnt_r <= usb_fb_tick ? '0 : usb_fb_cnt_r + 1'b1;
        end
    end

    // Fallback stays selected until the USB loop is up, locked and connected
    tick_switch #(
        .N  (2),
        .SW (1)
    ) u_usb_switch (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_tick    ({i_usb_cco_tick, usb_fb_tick}),
        .i_sel     (usb_conn_eff), // [R13]
        .o_tick    (usb_tick),
        .o_cur_sel ()
    );

    // Toggle per tick: equal high and low whichever source runs
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            usb_clk_r <= 1'b0;
        end else if (usb_tick) begin
            usb_clk_r <= ~usb_clk_r; // [R14]
        end
    end

    assign o_usb_clk = usb_clk_r; // [R11]

    //------------------------------------------------------------------
    // Register writes
    //------------------------------------------------------------------
    // Source select; reset lands on the RC oscillator
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            src_sel_r <= SRC_IRC; // [R1]
        end else if (wr && i_bus.addr == OFS_SRC_SEL && i_bus.wdata[1:0] != 2'h3) begin
            src_sel_r <= i_bus.wdata[1:0]; // [R2]
        end
    end

    // Main loop control; power-down drops it back to bypass
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || i_power_down) begin
            main_en_r   <= 1'b0; // [R6]
            main_conn_r <= 1'b0; // [R6]
        end else if (wr && i_bus.addr == OFS_MAIN_CTRL) begin
            main_en_r   <= i_bus.wdata[BIT_EN]; // [R7]
            // A connect while unlocked is refused
            main_conn_r <= i_bus.wdata[BIT_CONN] && i_bus.wdata[BIT_EN]
                           && main_locked; // [R7] [R15]
        end else if (!main_locked) begin
            main_conn_r <= 1'b0; // [R15]
        end
    end

    // Divider settings; change them only while disconnected
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            main_pre_r <= '0;
            main_fb_r  <= '0;
        end else if (wr && i_bus.addr == OFS_MAIN_CFG) begin
            main_pre_r <= i_bus.wdata[PRE_W-1:0];               // [R3]
            main_fb_r  <= i_bus.wdata[CFG_FB_LSB +: FB_W];      // [R4]
        end
    end

    // USB loop control, off after reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            usb_en_r   <= 1'b0; // [R12]
            usb_conn_r <= 1'b0;
        end else if (wr && i_bus.addr == OFS_USB_CTRL) begin
            usb_en_r   <= i_bus.wdata[BIT_EN];
            usb_conn_r <= i_bus.wdata[BIT_CONN] && i_bus.wdata[BIT_EN]
                          && usb_locked; // [R15]
        end else if (!usb_locked) begin
            usb_conn_r <= 1'b0; // [R15]
        end
    end

    // Peripheral selects and post-dividers
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            pclk_sel_r   <= '0;
            cpu_div_r    <= CPU_DIV_RST;
            usb_fb_div_r <= USB_FB_DIV_RST;
        end else if (wr && i_bus.addr == OFS_PCLK_SEL) begin
            pclk_sel_r <= i_bus.wdata[PCLK_SEL_W*NPER-1:0]; // [R9]
        end else if (wr && i_bus.addr == OFS_DIV) begin
            cpu_div_r    <= i_bus.wdata[DIV_W-1:0];
            usb_fb_div_r <= i_bus.wdata[DIV_USB_LSB +: DIV_W];
        end
    end

    //------------------------------------------------------------------
    // Register reads
    //------------------------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        rdata_nxt = '0;
        case (i_bus.addr)
            OFS_SRC_SEL:   rdata_nxt[1:0] = src_sel_r;
            OFS_MAIN_CTRL: begin
                rdata_nxt[BIT_EN]   = main_en_r;
                rdata_nxt[BIT_CONN] = main_conn_r;
            end
            OFS_MAIN_CFG: begin
                rdata_nxt[PRE_W-1:0]          = main_pre_r;
                rdata_nxt[CFG_FB_LSB +: FB_W] = main_fb_r;
            end
            OFS_MAIN_STAT: begin
                rdata_nxt[BIT_EN]   = main_en_r;
                rdata_nxt[BIT_CONN] = main_conn_eff;
                rdata_nxt[BIT_LOCK] = main_locked; // [R15]
            end
            OFS_USB_CTRL: begin
                rdata_nxt[BIT_EN]   = usb_en_r;
                rdata_nxt[BIT_CONN] = usb_conn_r;
            end
            OFS_USB_STAT: begin
                rdata_nxt[BIT_EN]   = usb_en_r;
                rdata_nxt[BIT_CONN] = usb_conn_eff;
                rdata_nxt[BIT_LOCK] = usb_locked; // [R15]
            end
            OFS_PCLK_SEL:  rdata_nxt[PCLK_SEL_W*NPER-1:0] = pclk_sel_r;
            OFS_DIV: begin
                rdata_nxt[DIV_W-1:0]          = cpu_div_r;
                rdata_nxt[DIV_USB_LSB +: DIV_W] = usb_fb_div_r;
            end
            default:       rdata_nxt = '0;
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rd ? rdata_nxt : '0;
        end
    end

endmodule : clk_ctrl_top

// ### verification/clk_ctrl_assertions.sv
// Port-level concurrent checks for the clock control top level
`timescale 1ns/10ps
module clk_ctrl_assertions
    import clk_ctrl_pkg::*;
#(
    parameter int NPER = 8
) (
    input wire logic                 i_ref_clk,
    input wire logic                 i_nrst,
    input wire reg_req_t             i_bus,
    input wire logic [DATA_W-1:0]    o_rdata,
    input wire osc_ticks_t           i_osc,
    input wire logic                 i_main_cco_tick,
    input wire logic                 i_usb_cco_tick,
    input wire logic                 i_power_down,
    input wire pll_cfg_t             o_main_pll_cfg,
    input wire logic                 o_usb_pll_pwr,
    input wire logic                 o_cpu_clk_en,
    input wire logic [NPER-1:0]      o_pclk_en,
    input wire logic                 o_usb_clk
);
    //------------------------------------------------------------------
    // Single clock domain, synchronous active-low reset
    //------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // Reset leaves both loops off and the CPU on the RC ticks
    AST_RST_IRC: assert property ($rose(i_nrst) |-> o_cpu_clk_en == i_osc.internal_rc_osc)
        else $error("cpu tick not from rc source after reset");
    AST_RST_PWR: assert property ($rose(i_nrst) |-> !o_main_pll_cfg.pwr && !o_usb_pll_pwr)
        else $error("loop powered after reset");
    AST_PWRDN: assert property (i_power_down |=> !o_main_pll_cfg.pwr)
        else $error("main loop left on in power-down");
    // Peripheral enables are thinned copies of the cpu tick
    AST_PCLK_IN_CPU: assert property (|o_pclk_en |-> o_cpu_clk_en)
        else $error("peripheral tick without cpu tick");
    AST_CFG_WRITE: assert property ((i_bus.we && i_bus.addr == OFS_MAIN_CFG) |=>
        o_main_pll_cfg.pre_m1 == $past(i_bus.wdata[7:0])
        && o_main_pll_cfg.fb_m1 == $past(i_bus.wdata[22:8]))
        else $error("divider fields not taken from write");
    AST_CFG_HOLD: assert property (!$past(i_bus.we) |->
        $stable(o_main_pll_cfg.pre_m1) && $stable(o_main_pll_cfg.fb_m1))
        else $error("divider fields moved without a write");
    AST_USB_WRITE: assert property ((i_bus.we && i_bus.addr == OFS_USB_CTRL) |=>
        o_usb_pll_pwr == $past(i_bus.wdata[BIT_EN]))
        else $error("usb loop power not from write");
    AST_USB_SRC: assert property ($changed(o_usb_clk) |-> $past(i_usb_cco_tick)
        || $past(i_main_cco_tick) || $past(i_usb_cco_tick, 2) || $past(i_main_cco_tick, 2))
        else $error("usb clock moved without a loop tick");
    AST_STAT_EN: assert property (($past(i_bus.re) && $past(i_bus.addr) == OFS_MAIN_STAT)
        |-> o_rdata[BIT_EN] == $past(o_main_pll_cfg.pwr))
        else $error("status enable differs from loop power");
    AST_CONN_LOCK: assert property (($past(i_bus.re) && $past(i_bus.addr) == OFS_MAIN_STAT)
        |-> !o_rdata[BIT_CONN] || o_rdata[BIT_LOCK])
        else $error("connected while unlocked");
    AST_RDATA_IDLE: assert property (o_rdata != '0 |-> $past(i_bus.re))
        else $error("read data outside a read slot");

    cover property ($rose(o_main_pll_cfg.pwr));
    cover property (i_power_down && o_main_pll_cfg.pwr);
    cover property (o_usb_pll_pwr && o_usb_clk);
endmodule : clk_ctrl_assertions

bind clk_ctrl_top clk_ctrl_assertions #(.NPER(NPER)) u_clk_ctrl_assertions (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_osc(i_osc), .i_main_cco_tick(i_main_cco_tick), .i_usb_cco_tick(i_usb_cco_tick),
    .i_power_down(i_power_down), .o_main_pll_cfg(o_main_pll_cfg),
    .o_usb_pll_pwr(o_usb_pll_pwr), .o_cpu_clk_en(o_cpu_clk_en), .o_pclk_en(o_pclk_en),
    .o_usb_clk(o_usb_clk));

// ### verification/clk_ctrl_top_tb.sv
// Self-checking bench for the clock control top level
`timescale 1ns/10ps
module clk_ctrl_top_tb;
    import clk_ctrl_pkg::*;
    //------------------------------------------------------------------
    // Clock, stimulus and rate counters
    //------------------------------------------------------------------
    logic              i_ref_clk = 1'b0;
    logic              i_nrst    = 1'b0;
    reg_req_t          bus       = '0;
    osc_ticks_t        osc       = '0;
    logic              pd        = 1'b0;
    logic [DATA_W-1:0] rdata;
    pll_cfg_t          cfg;
    logic              usb_pwr, cpu_en, usb_clk, usb_q;
    logic [7:0]        pclk;
    int                err_count = 0, check_count = 0, cyc = 0, cpu_n = 0, usb_t = 0, usb_h = 0;
    int                pc_n [8] = '{default: 0};

    always #50 i_ref_clk = ~i_ref_clk;

    // Fixed tick ratios so that every rate can be counted exactly
    always @(posedge i_ref_clk) begin
        cyc      <= cyc + 1;
        osc.internal_rc_osc  <= (cyc % 2 == 0);
        osc.main <= (cyc % 4 == 1);
        osc.rtc  <= (cyc % 8 == 3);
        cpu_n    <= cpu_n + int'(cpu_en);
        usb_h    <= usb_h + int'(usb_clk);
        usb_t    <= usb_t + int'(usb_clk !== usb_q);
        usb_q    <= usb_clk;
        foreach (pc_n[i]) pc_n[i] <= pc_n[i] + int'(pclk[i]);
    end

    // Loop oscillators tied to run flat out; dividers set the rates
    clk_ctrl_top #(.NPER(8)) u_clk_ctrl_top (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
        .i_osc(osc), .i_main_cco_tick(1'b1), .i_usb_cco_tick(1'b1), .i_power_down(pd),
        .o_main_pll_cfg(cfg), .o_usb_pll_pwr(usb_pwr), .o_cpu_clk_en(cpu_en),
        .o_pclk_en(pclk), .o_usb_clk(usb_clk));

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_ref_clk);
        bus.we <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
        @(posedge i_ref_clk);
        bus.re <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rdchk

    // Settle past any switch drain, then count cpu ticks
    task automatic rate(input int n, input int exp);
        int c0;
        cycles(40);
        c0 = cpu_n;
        cycles(n);
        chk(cpu_n - c0, exp);
    endtask : rate

    task automatic usb_meas(input int exp_t);
        int t0, h0;
        cycles(40);
        t0 = usb_t;
        h0 = usb_h;
        cycles(100);
        chk(usb_t - t0, exp_t);
        chk(usb_h - h0, 50);
    endtask : usb_meas

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic t_reset();
        rdchk(OFS_SRC_SEL, '0);
        rdchk(OFS_MAIN_STAT, '0);
        rdchk(OFS_USB_STAT, '0);
        rdchk(OFS_DIV, 32'h0000_0403);
        rdchk(8'h20, '0);
        rate(64, 32);
    endtask : t_reset

    // Each peripheral gets its own divide code from the cpu tick
    task automatic t_pclk();
        int p0 [8];
        wr(OFS_PCLK_SEL, 32'h0000_E4E4);
        cycles(40);
        p0 = pc_n;
        cycles(64);
        foreach (p0[i]) chk(pc_n[i] - p0[i], 32 >> (i % 4));
    endtask : t_pclk

    task automatic t_src();
        for (int s = 0; s < 3; s++) begin
            wr(OFS_SRC_SEL, 32'(s));
            rate(64, 32 >> s);
        end
        wr(OFS_SRC_SEL, 32'h0000_0003);
        rdchk(OFS_SRC_SEL, 32'h0000_0002);
        wr(OFS_SRC_SEL, 32'h0000_0001);
        rate(64, 16);
    endtask : t_src

    // Connect refused until lock, loop rate, then power-down bypass
    task automatic t_lock();
        wr(OFS_MAIN_CFG, 32'h0000_0300);
        wr(OFS_DIV, 32'h0000_0401);
        wr(OFS_MAIN_CTRL, 32'h0000_0003);
        rdchk(OFS_MAIN_STAT, 32'h0000_0001);
        rate(64, 16);
        cycles(200);
        rdchk(OFS_MAIN_STAT, 32'h0000_0005);
        wr(OFS_MAIN_CTRL, 32'h0000_0003);
        rdchk(OFS_MAIN_STAT, 32'h0000_0007);
        rate(64, 32);
        @(posedge i_ref_clk);
        pd <= 1'b1;
        @(posedge i_ref_clk);
        pd <= 1'b0;
        rdchk(OFS_MAIN_CTRL, '0);
        rate(64, 16);
    endtask : t_lock

    task automatic t_usb();
        wr(OFS_MAIN_CTRL, 32'h0000_0001);
        usb_meas(20);
        wr(OFS_USB_CTRL, 32'h0000_0001);
        cycles(200);
        rdchk(OFS_USB_STAT, 32'h0000_0005);
        wr(OFS_USB_CTRL, 32'h0000_0003);
        rdchk(OFS_USB_STAT, 32'h0000_0007);
        usb_meas(100);
        wr(OFS_USB_CTRL, '0);
        rdchk(OFS_USB_STAT, '0);
    endtask : t_usb

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    initial begin
        cycles(5);
        i_nrst <= 1'b1;
        t_reset();
        t_pclk();
        t_src();
        t_lock();
        t_usb();
        conclude();
    end

    // Run needs about 2000 cycles; cut off far beyond
    initial begin
        #2_000_000;
        err_count++;
        conclude();
    end
endmodule : clk_ctrl_top_tb
